// [hw/awpg_pkg.sv]
// Shared constants and types of the advanced waveform timer group.
package awpg_pkg;

  // Widths and counts of one group.
  localparam int CNT_W    = 32;
  localparam int PSC_W    = 8;
  localparam int REP_W    = 8;
  localparam int DT_W     = 8;
  localparam int NUM_CNT  = 4;
  localparam int NUM_LEAD = 3;
  localparam int NUM_PIN  = 6;
  localparam int SRC_W    = 3;

  // Sync source code that selects the external sync pin; codes below it pick a counter.
  localparam logic [SRC_W-1:0] SYNC_EXT = 3'h4;

  // Flag vector layout.
  localparam int FLG_UPD   = 0;
  localparam int FLG_START = 4;
  localparam int FLG_CAPT  = 8;
  localparam int FLG_CMP   = 11;
  localparam int FLG_HALL  = 14;
  localparam int FLG_W     = 15;

  // Counting direction; up-and-down gives center-aligned waveforms.
  typedef enum logic [1:0] {AWPG_DIR_UP, AWPG_DIR_DOWN, AWPG_DIR_UPDN} awpg_dir_t;

  // What a sync source does to a counter.
  typedef enum logic [1:0] {AWPG_SYNC_OFF, AWPG_SYNC_RESET, AWPG_SYNC_GATE,
                            AWPG_SYNC_TRIG} awpg_sync_t;

  // Channel function.
  typedef enum logic [1:0] {AWPG_CH_OFF, AWPG_CH_PWM, AWPG_CH_CAPT, AWPG_CH_EDGE} awpg_chmode_t;

  // Configuration of one counter.
  typedef struct packed {
    logic             en;
    awpg_dir_t        dir;
    logic [PSC_W-1:0] psc;
    logic [CNT_W-1:0] period;
    logic [REP_W-1:0] rep;
    awpg_sync_t       sync_mode;
    logic [SRC_W-1:0] sync_src;
  } awpg_cnt_cfg_t;

  // Configuration of one channel.
  typedef struct packed {
    awpg_chmode_t     mode;
    logic             pol;
    logic [CNT_W-1:0] cmp;
  } awpg_ch_cfg_t;

  // Configuration of one lead/follower pair.
  typedef struct packed {
    logic            couple;
    logic            ident;
    logic            dt_mode;
    logic [DT_W-1:0] dt_len;
  } awpg_pair_cfg_t;

endpackage : awpg_pkg

// [hw/awpg_counter.sv]
// Prescaled auto-reload counter with repetition count and period shadow.
`timescale 1ns/100ps
module awpg_counter #(
  parameter bit UP_ONLY = 1'b0
) (
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    sclr,
  // Configuration.
  input  wire awpg_pkg::awpg_cnt_cfg_t cfg,
  // Step source, sync and init.
  input  wire logic                    ext_mode,
  input  wire logic                    ext_step,
  input  wire logic                    ext_down,
  input  wire logic                    restart,
  input  wire logic                    gate,
  input  wire logic                    trig,
  // State and events.
  output logic [awpg_pkg::CNT_W-1:0]   cnt_q,
  output logic                         upd_q,
  output logic                         start_q,
  output logic                         load_q
);

  logic [awpg_pkg::PSC_W-1:0] psc_q;
  logic [awpg_pkg::REP_W-1:0] rep_q;
  logic [awpg_pkg::CNT_W-1:0] per_q;
  logic                       run_q;
  logic                       down_q;
  logic                       tick;
  logic                       step;
  logic                       dn;
  logic                       run_set;
  awpg_pkg::awpg_dir_t        dir;

  // The follower counter can only count up.
  assign dir     = UP_ONLY ? awpg_pkg::AWPG_DIR_UP : cfg.dir;
  assign tick    = run_q && (psc_q == cfg.psc);
  assign step    = run_q && gate && (ext_mode ? ext_step : tick);
  assign dn      = ext_mode ? ext_down : (dir == awpg_pkg::AWPG_DIR_DOWN) || down_q;
  assign run_set = !run_q && cfg.en && !sclr
                   && ((cfg.sync_mode != awpg_pkg::AWPG_SYNC_TRIG) || trig);

  // Prescaler divides by psc plus one, so 1 to 256.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      psc_q <= '0;
    end else if (sclr || !run_q || tick) begin
      psc_q <= '0;
    end else begin
      psc_q <= psc_q + 8'h01;
    end
  end

  // Run state, with an optional trigger start.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q   <= 1'b0;
      start_q <= 1'b0;
    end else begin
      start_q <= run_set;
      if (sclr || !cfg.en) begin
        run_q <= 1'b0;
      end else if (run_set) begin
        run_q <= 1'b1;
      end
    end
  end

  // Count, turn around or wrap with reload from the active period.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      down_q <= 1'b0;
      upd_q  <= 1'b0;
    end else begin
      upd_q <= 1'b0;
      if (sclr) begin
        cnt_q  <= '0;
        down_q <= 1'b0;
      end else if (restart) begin
        cnt_q  <= (dir == awpg_pkg::AWPG_DIR_DOWN) ? per_q : '0;
        down_q <= 1'b0;
        upd_q  <= 1'b1;
      end else if (step && !dn) begin
        if (cnt_q >= per_q) begin
          upd_q <= 1'b1;
          if (dir == awpg_pkg::AWPG_DIR_UPDN && !ext_mode) begin
            down_q <= 1'b1;
          end else begin
            cnt_q <= '0;
          end
        end else begin
          cnt_q <= cnt_q + 32'h1;
        end
      end else if (step) begin
        if (cnt_q == '0) begin
          upd_q <= 1'b1;
          if (dir == awpg_pkg::AWPG_DIR_UPDN && !ext_mode) begin
            down_q <= 1'b0;
          end else begin
            cnt_q <= per_q;
          end
        end else begin
          cnt_q <= cnt_q - 32'h1;
        end
      end
    end
  end

  // Repetition count gates the transfer of buffered settings.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rep_q  <= '0;
      per_q  <= '0;
      load_q <= 1'b0;
    end else begin
      load_q <= 1'b0;
      if (!run_q || sclr || restart || (upd_q && rep_q == '0)) begin
        rep_q  <= cfg.rep;
        per_q  <= cfg.period;
        load_q <= 1'b1;
      end else if (upd_q) begin
        rep_q <= rep_q - 8'h01;
      end
    end
  end

endmodule : awpg_counter

// [hw/awpg_deadtime.sv]
// Lead and follower output stage with dead-time insertion.
`timescale 1ns/100ps
module awpg_deadtime (
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     sclr,
  // Waveforms and settings.
  input  wire logic                     ref_i,
  input  wire logic                     follow_ref,
  input  wire awpg_pkg::awpg_pair_cfg_t cfg,
  input  wire logic                     lead_en,
  input  wire logic                     follow_en,
  input  wire logic                     lead_pol,
  input  wire logic                     follow_pol,
  // Outputs.
  output logic                          lead_o,
  output logic                          follow_o
);

  logic                      ref_q;
  logic [awpg_pkg::DT_W-1:0] dt_q;
  logic                      settled;

  assign settled = (dt_q == cfg.dt_len);

  // Dead-time counter restarts on every edge of the lead waveform.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_q <= 1'b0;
      dt_q  <= '0;
    end else begin
      ref_q <= ref_i;
      if (ref_i != ref_q) begin
        dt_q <= '0;
      end else if (!settled) begin
        dt_q <= dt_q + 8'h01;
      end
    end
  end

  // Mode 0 delays both rising edges; mode 1 delays only the follower.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lead_o   <= 1'b0;
      follow_o <= 1'b0;
    end else if (sclr) begin
      lead_o   <= 1'b0;
      follow_o <= 1'b0;
    end else begin
      lead_o <= lead_pol ^ (lead_en && ref_q
                && (settled || !cfg.couple || cfg.dt_mode));
      if (!follow_en) begin
        follow_o <= follow_pol;
      end else if (!cfg.couple) begin
        follow_o <= follow_pol ^ follow_ref;
      end else if (cfg.ident) begin
        if (settled) begin
          follow_o <= follow_pol ^ ref_q;
        end
      end else begin
        follow_o <= follow_pol ^ (!ref_q && settled);
      end
    end
  end

endmodule : awpg_deadtime

// [hw/awpg_group.sv]
// One advanced waveform timer group: four counters, six channel pins.
`timescale 1ns/100ps
// Behaviour
// - Four 32-bit reload counters per group, two groups.
// - Counters count up, down or up-down, reloading.
// - Counter map: a, a-follow, b pair, c pair.
// - Each counter has an 8-bit prescaler, 1..256.
// - Lead channels capture, count edges, generate PWM.
// - Follower a makes its own up-count waveform.
// - Follower a may copy or invert lead a.
// - Followers b, c only copy or invert leads.
// - Coupled pairs get a dead-time gap.
// - Dead time has programmable length and mode.
// - Shared-counter pairs always have equal period.
// - Sync inputs reset, gate or trigger counters.
// - Repetition count delays settings transfer.
// - Update event on wrap or initialization.
// - Events on start, capture and compare match.
// - Polarity, duty, period change at period boundary.
// - Quadrature encoder and Hall sensor support.
module awpg_group (
  // Clock and reset.
  input  wire logic                                                SYS_CLK,
  input  wire logic                                                RST_N,
  input  wire logic                                                SYNC_CLR,
  // Configuration.
  input  wire awpg_pkg::awpg_cnt_cfg_t  [awpg_pkg::NUM_CNT-1:0]    CNT_CFG,
  input  wire awpg_pkg::awpg_ch_cfg_t   [awpg_pkg::NUM_PIN-1:0]    CH_CFG,
  input  wire awpg_pkg::awpg_pair_cfg_t [awpg_pkg::NUM_LEAD-1:0]   PAIR_CFG,
  input  wire logic                                                ENC_EN,
  input  wire logic                                                HALL_EN,
  input  wire logic [awpg_pkg::NUM_CNT-1:0]                        SW_INIT,
  // Flags.
  input  wire logic [awpg_pkg::FLG_W-1:0]                          FLAG_CLR,
  input  wire logic [awpg_pkg::FLG_W-1:0]                          FLAG_EN,
  output logic      [awpg_pkg::FLG_W-1:0]                          FLAG_Q,
  output logic                                                     IRQ,
  // Measured values.
  output logic      [awpg_pkg::NUM_CNT-1:0][awpg_pkg::CNT_W-1:0]   CNT_VAL,
  output logic      [awpg_pkg::NUM_LEAD-1:0][awpg_pkg::CNT_W-1:0]  CAPT_VAL,
  output logic      [awpg_pkg::CNT_W-1:0]                          HALL_VAL,
  // Channel pins and external sync.
  input  wire logic [awpg_pkg::NUM_PIN-1:0]                        PIN_I,
  output logic      [awpg_pkg::NUM_PIN-1:0]                        PIN_O,
  output logic      [awpg_pkg::NUM_PIN-1:0]                        PIN_OE,
  input  wire logic                                                SYNC_IN
);

  localparam int NP = awpg_pkg::NUM_PIN;
  localparam int NC = awpg_pkg::NUM_CNT;
  localparam int NL = awpg_pkg::NUM_LEAD;

  // Counter that serves a lead channel: a uses 0, b uses 2, c uses 3.
  function automatic int lead_cnt(input int j);
    lead_cnt = (j == 0) ? 0 : j + 1;
  endfunction : lead_cnt

  // Channel whose compare and polarity a counter carries.
  function automatic int cnt_ch(input int k);
    cnt_ch = (k < 2) ? k : 2 * (k - 1);
  endfunction : cnt_ch

  logic [NP:0]                        s1_q;
  logic [NP:0]                        s2_q;
  logic [NP:0]                        s3_q;
  logic [NP:0]                        in_q;
  logic [NP:0]                        prev_q;
  logic [NP:0]                        rise;
  logic [NP:0]                        chg;
  logic                               enc_step;
  logic                               enc_down;
  logic                               hall_ev;
  logic [NC-1:0][awpg_pkg::CNT_W-1:0] cnt;
  logic [NC-1:0][awpg_pkg::CNT_W-1:0] cmp_q;
  logic [NC-1:0]                      upd;
  logic [NC-1:0]                      start;
  logic [NC-1:0]                      load;
  logic [NC-1:0]                      ref_w;
  logic [NC-1:0]                      match_q;
  logic [NC-1:0]                      ext_mode;
  logic [NC-1:0]                      ext_step;
  logic [NC-1:0]                      restart;
  logic [NC-1:0]                      gate;
  logic [NC-1:0]                      trig;
  logic [NP-1:0]                      pol_q;
  logic [NP-1:0]                      drv_o;
  logic [NP-1:0]                      oe_d;
  logic [NL-1:0]                      capt_ev;
  logic [NL-1:0]                      cmp_ev;
  logic [awpg_pkg::FLG_W-1:0]         flag_set;
  awpg_pkg::awpg_pair_cfg_t [NL-1:0]  pcfg;

  // Outside inputs pass three flops; a change counts when the last two agree.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      in_q   <= '0;
      prev_q <= '0;
    end else begin
      s1_q   <= {SYNC_IN, PIN_I};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      in_q   <= (s2_q & s3_q) | (in_q & (s2_q | s3_q));
      prev_q <= in_q;
    end
  end

  assign rise = in_q & ~prev_q;
  assign chg  = in_q ^ prev_q;

  // Quadrature decode on pins a and a-follow, four steps per cycle.
  assign enc_step = chg[0] | chg[1];
  assign enc_down = prev_q[0] ^ in_q[1];
  // Any Hall edge on the three lead pins.
  assign hall_ev  = HALL_EN && (chg[0] || chg[2] || chg[4]);

  // Sync routing, step sources and init per counter.
  always_comb begin
    for (int k = 0; k < NC; k++) begin
      logic ev;
      logic lvl;
      ev  = 1'b0;
      lvl = 1'b0;
      if (CNT_CFG[k].sync_src == awpg_pkg::SYNC_EXT) begin
        ev  = rise[NP];
        lvl = in_q[NP];
      end else begin
        ev  = upd[CNT_CFG[k].sync_src[1:0]];
        lvl = ref_w[CNT_CFG[k].sync_src[1:0]];
      end
      trig[k]     = ev;
      gate[k]     = (CNT_CFG[k].sync_mode != awpg_pkg::AWPG_SYNC_GATE) || lvl;
      restart[k]  = SW_INIT[k] || ((CNT_CFG[k].sync_mode == awpg_pkg::AWPG_SYNC_RESET) && ev)
                    || ((k == 1) && hall_ev);
      ext_mode[k] = (k != 1) && (CH_CFG[cnt_ch(k)].mode == awpg_pkg::AWPG_CH_EDGE);
      ext_step[k] = rise[cnt_ch(k)];
      if (k == 0 && ENC_EN) begin
        ext_mode[k] = 1'b1;
        ext_step[k] = enc_step;
      end
    end
  end

  // Four counters make one group; the chip places two group instances.
  for (genvar g = 0; g < NC; g++) begin : g_cnt
    awpg_counter #(
      .UP_ONLY (g == 1)
    ) u_cnt (
      .clk      (SYS_CLK),
      .rst_n    (RST_N),
      .sclr     (SYNC_CLR),
      .cfg      (CNT_CFG[g]),
      .ext_mode (ext_mode[g]),
      .ext_step (ext_step[g]),
      .ext_down (ENC_EN && g == 0 && enc_down),
      .restart  (restart[g]),
      .gate     (gate[g]),
      .trig     (trig[g]),
      .cnt_q    (cnt[g]),
      .upd_q    (upd[g]),
      .start_q  (start[g]),
      .load_q   (load[g])
    );
    // Reference level: high while the count is below the active compare.
    assign ref_w[g] = cnt[g] < cmp_q[g];
  end

  // Compare and polarity shadows move to active on each counter load: at a period boundary, on init or clear, or while stopped.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmp_q <= '0;
      pol_q <= '0;
    end else begin
      for (int k = 0; k < NC; k++) begin
        if (load[k]) begin
          cmp_q[k]           <= CH_CFG[cnt_ch(k)].cmp;
          pol_q[cnt_ch(k)]   <= CH_CFG[cnt_ch(k)].pol;
          if (k >= 2) begin
            pol_q[cnt_ch(k) + 1] <= CH_CFG[cnt_ch(k) + 1].pol;
          end
        end
      end
    end
  end

  // Followers b and c are always coupled; they have no compare of their own.
  always_comb begin
    for (int j = 0; j < NL; j++) begin
      pcfg[j] = PAIR_CFG[j];
      if (j != 0) begin
        pcfg[j].couple = 1'b1;
      end
    end
  end

  // One output stage per pair; the follower derives from the lead reference, except follower a when uncoupled.
  for (genvar j = 0; j < NL; j++) begin : g_pair
    awpg_deadtime u_dt (
      .clk        (SYS_CLK),
      .rst_n      (RST_N),
      .sclr       (SYNC_CLR),
      .ref_i      (ref_w[lead_cnt(j)]),
      .follow_ref ((j == 0) && ref_w[1]),
      .cfg        (pcfg[j]),
      .lead_en    (CH_CFG[2*j].mode == awpg_pkg::AWPG_CH_PWM),
      .follow_en  (CH_CFG[2*j+1].mode == awpg_pkg::AWPG_CH_PWM),
      .lead_pol   (pol_q[2*j]),
      .follow_pol (pol_q[2*j+1]),
      .lead_o     (drv_o[2*j]),
      .follow_o   (drv_o[2*j+1])
    );
  end

  assign PIN_O = drv_o;

  // A pin drives only while its channel generates and no sensor owns it.
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      oe_d[p] = (CH_CFG[p].mode == awpg_pkg::AWPG_CH_PWM);
    end
    if (ENC_EN) begin
      oe_d[1:0] = '0;
    end
    if (HALL_EN) begin
      oe_d[0] = 1'b0;
      oe_d[2] = 1'b0;
      oe_d[4] = 1'b0;
    end
  end

  // Output enables; cleared at once by the synchronous clear.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PIN_OE <= '0;
    end else if (SYNC_CLR) begin
      PIN_OE <= '0;
    end else begin
      PIN_OE <= oe_d;
    end
  end

  // Capture and compare events of the lead channels.
  always_comb begin
    for (int j = 0; j < NL; j++) begin
      capt_ev[j] = !HALL_EN && (CH_CFG[2*j].mode == awpg_pkg::AWPG_CH_CAPT)
                   && rise[2*j];
      cmp_ev[j]  = !match_q[lead_cnt(j)]
                   && (cnt[lead_cnt(j)] == cmp_q[lead_cnt(j)]);
    end
  end

  // Captured counts, Hall timing and compare history.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CAPT_VAL <= '0;
      HALL_VAL <= '0;
      match_q  <= '0;
      CNT_VAL  <= '0;
    end else begin
      CNT_VAL <= cnt;
      for (int k = 0; k < NC; k++) begin
        match_q[k] <= (cnt[k] == cmp_q[k]);
      end
      for (int j = 0; j < NL; j++) begin
        if (capt_ev[j]) begin
          CAPT_VAL[j] <= cnt[lead_cnt(j)];
        end
      end
      if (hall_ev) begin
        HALL_VAL <= cnt[1];
      end
    end
  end

  // Event sources for the sticky flags.
  always_comb begin
    flag_set = '0;
    flag_set[awpg_pkg::FLG_UPD +: NC]   = upd;
    flag_set[awpg_pkg::FLG_START +: NC] = start;
    flag_set[awpg_pkg::FLG_CAPT +: NL]  = capt_ev;
    flag_set[awpg_pkg::FLG_CMP +: NL]   = cmp_ev;
    flag_set[awpg_pkg::FLG_HALL]        = hall_ev;
  end

  // Sticky flags: a new event wins over a clear in the same cycle.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FLAG_Q <= '0;
      IRQ    <= 1'b0;
    end else if (SYNC_CLR) begin
      FLAG_Q <= '0;
      IRQ    <= 1'b0;
    end else begin
      FLAG_Q <= (FLAG_Q & ~FLAG_CLR) | flag_set;
      IRQ    <= |(FLAG_Q & FLAG_EN);
    end
  end

endmodule : awpg_group

// [testbench/awpg_pin_model.sv]
// Far-side pin model for the channel pins.
`timescale 1ns/100ps
module awpg_pin_model (
  // Group side and sensor levels.
  input  wire logic [5:0] pin_o,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] drv,
  output logic      [5:0] pin_i
);
  // The wire carries the group's drive when enabled, else the level held by the sensor.
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & drv);
endmodule : awpg_pin_model

// [testbench/awpg_group_sva.sv]
// Port checker for the waveform timer group.
`timescale 1ns/100ps
module awpg_group_chk (
  // Watched ports.
  input wire logic                           SYS_CLK,
  input wire logic                           RST_N,
  input wire logic                           SYNC_CLR,
  input wire logic                           HALL_EN,
  input wire awpg_pkg::awpg_cnt_cfg_t  [3:0] CNT_CFG,
  input wire awpg_pkg::awpg_ch_cfg_t   [5:0] CH_CFG,
  input wire awpg_pkg::awpg_pair_cfg_t [2:0] PAIR_CFG,
  input wire logic [14:0]                    FLAG_CLR,
  input wire logic [14:0]                    FLAG_EN,
  input wire logic [14:0]                    FLAG_Q,
  input wire logic                           IRQ,
  input wire logic [3:0][31:0]               CNT_VAL,
  input wire logic [5:0]                     PIN_O,
  input wire logic [5:0]                     PIN_OE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // Relations between flags, counters and pins.
  irq_mask_a: assert property (!$past(SYNC_CLR) |->
    IRQ == |($past(FLAG_Q) & $past(FLAG_EN))) else $error("IRQ differs from masked flags.");
  sync_clear_a: assert property (SYNC_CLR |=>
    FLAG_Q == 15'h0 && PIN_OE == 6'h0 && !IRQ) else $error("Clear left state set.");
  flag_hold_a: assert property (!$past(SYNC_CLR) |->
    ($past(FLAG_Q) & ~FLAG_Q & ~$past(FLAG_CLR)) == 15'h0) else $error("Flag lost.");
  up_step_a: assert property ($changed(CNT_VAL[1]) |->
    CNT_VAL[1] == $past(CNT_VAL[1]) + 32'h1 || CNT_VAL[1] == 32'h0) else $error("Bad step.");
  start_flag_a: assert property ($rose(CNT_CFG[1].en) && CNT_CFG[1].sync_mode ==
    awpg_pkg::AWPG_SYNC_OFF |-> ##[1:3] FLAG_Q[5]) else $error("No start flag.");
  capt_float_a: assert property ((CH_CFG[2].mode == awpg_pkg::AWPG_CH_CAPT)[*3]
    |-> !PIN_OE[2]) else $error("Capture pin driven.");
  out_drive_a: assert property ((CH_CFG[4].mode == awpg_pkg::AWPG_CH_PWM &&
    CNT_CFG[3].en && !SYNC_CLR && !HALL_EN)[*4] |-> PIN_OE[4])
    else $error("Output pin not driven.");
  dead_gap_a: assert property (!PAIR_CFG[2].ident && !CH_CFG[4].pol && !CH_CFG[5].pol
    |-> !(PIN_O[4] && PIN_O[5])) else $error("Pair outputs overlap.");
  cover property (FLAG_Q[9]);
  cover property (IRQ);
  cover property ($rose(PIN_O[5]));
  cover property (FLAG_Q[14]);
endmodule : awpg_group_chk
bind awpg_group awpg_group_chk awpg_group_chk_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .SYNC_CLR(SYNC_CLR), .HALL_EN(HALL_EN), .CNT_CFG(CNT_CFG), .CH_CFG(CH_CFG),
  .PAIR_CFG(PAIR_CFG),
  .FLAG_CLR(FLAG_CLR), .FLAG_EN(FLAG_EN), .FLAG_Q(FLAG_Q), .IRQ(IRQ), .CNT_VAL(CNT_VAL),
  .PIN_O(PIN_O), .PIN_OE(PIN_OE));

// [testbench/awpg_group_tb.sv]
// Self-checking bench for the waveform timer group.
`timescale 1ns/100ps
module awpg_group_tb;
  // Stimulus and observed signals.
  logic                           sys_clk  = 1'b0;
  logic                           rst_n    = 1'b0;
  logic                           sync_clr = 1'b0;
  awpg_pkg::awpg_cnt_cfg_t  [3:0] cnt_cfg  = '0;
  awpg_pkg::awpg_ch_cfg_t   [5:0] ch_cfg   = '0;
  awpg_pkg::awpg_pair_cfg_t [2:0] pair_cfg = '0;
  logic [14:0]                    flag_en  = 15'h0;
  logic                           enc_en   = 1'b0;
  logic                           hall_en  = 1'b0;
  logic                           sync_in  = 1'b0;
  logic [3:0]                     sw_init  = 4'h0;
  logic [14:0]                    flag_clr = 15'h0;
  logic [31:0]                    hall_val;
  logic [14:0]                    flag_q;
  logic                           irq;
  logic [3:0][31:0]               cnt_val;
  logic [2:0][31:0]               capt_val;
  logic [5:0]                     pin_i;
  logic [5:0]                     pin_o;
  logic [5:0]                     pin_oe;
  logic [5:0]                     drv      = 6'h0;
  int                             bad_count = 0, compares = 0, mx, h4, h5, hb;
  // Free-running 50 MHz clock.
  always #10 sys_clk = ~sys_clk;
  // Group under test and the pin partner.
  awpg_group awpg_group_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .SYNC_CLR(sync_clr),
    .CNT_CFG(cnt_cfg), .CH_CFG(ch_cfg), .PAIR_CFG(pair_cfg), .ENC_EN(enc_en),
    .HALL_EN(hall_en), .SW_INIT(sw_init), .FLAG_CLR(flag_clr), .FLAG_EN(flag_en),
    .FLAG_Q(flag_q), .IRQ(irq), .CNT_VAL(cnt_val), .CAPT_VAL(capt_val), .HALL_VAL(hall_val),
    .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe), .SYNC_IN(sync_in));
  awpg_pin_model awpg_pin_model_inst (.pin_o(pin_o), .pin_oe(pin_oe), .drv(drv), .pin_i(pin_i));
  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Steps to the falling edge, where inputs change.
  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : tick
  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // Test sequence.
  initial begin
    tick(16);
    rst_n = 1'b1;
    check(flag_q | pin_oe | irq, 32'h0);
    cnt_cfg[1].period = 32'h5;
    cnt_cfg[1].en = 1'b1;
    flag_en = 15'h2;
    mx = 0;
    repeat (30) begin
      tick(1);
      if (cnt_val[1] > mx) mx = cnt_val[1];
    end
    check(mx, 32'h5);
    check(flag_q[1], 1'b1);
    check(flag_q[5], 1'b1);
    check(irq, 1'b1);
    cnt_cfg[0].psc = 8'h3;
    cnt_cfg[0].period = 32'hffff;
    cnt_cfg[0].en = 1'b1;
    tick(12);
    mx = cnt_val[0];
    tick(8);
    check(cnt_val[0] - mx, 32'h2);
    ch_cfg[2].mode = awpg_pkg::AWPG_CH_CAPT;
    cnt_cfg[2].period = 32'hffff;
    cnt_cfg[2].en = 1'b1;
    tick(20);
    check(pin_oe[2], 1'b0);
    drv[2] = 1'b1;
    tick(8);
    check(flag_q[9], 1'b1);
    check(capt_val[1] > 32'h10 && capt_val[1] < cnt_val[2], 1'b1);
    cnt_cfg[3].dir = awpg_pkg::AWPG_DIR_UPDN;
    cnt_cfg[3].period = 32'h8;
    ch_cfg[4].cmp = 32'h3;
    ch_cfg[4].mode = awpg_pkg::AWPG_CH_PWM;
    ch_cfg[5].mode = awpg_pkg::AWPG_CH_PWM;
    pair_cfg[2].dt_len = 8'h2;
    cnt_cfg[3].en = 1'b1;
    tick(40);
    h4 = 0;
    h5 = 0;
    hb = 0;
    repeat (64) begin
      tick(1);
      h4 += pin_o[4];
      h5 += pin_o[5];
      hb += pin_o[4] & pin_o[5];
    end
    check(pin_oe[5:4], 2'h3);
    check(hb, 32'h0);
    check(h4 > 0 && h5 > 0, 1'b1);
    flag_clr = 15'h200;
    tick(1);
    flag_clr = 15'h0;
    check(flag_q[9], 1'b0);
    sw_init = 4'h1;
    tick(1);
    sw_init = 4'h0;
    tick(2);
    check(cnt_val[0] < 32'h2, 1'b1);
    check(flag_q[0], 1'b1);
    enc_en = 1'b1;
    tick(2);
    mx = cnt_val[0];
    drv[1:0] = 2'h1;
    tick(6);
    drv[1:0] = 2'h3;
    tick(6);
    drv[1:0] = 2'h2;
    tick(6);
    drv[1:0] = 2'h0;
    tick(8);
    check(cnt_val[0] - mx, 32'h4);
    drv[1:0] = 2'h2;
    tick(8);
    check(cnt_val[0] - mx, 32'h3);
    enc_en = 1'b0;
    hall_en = 1'b1;
    cnt_cfg[1].period = 32'hffff;
    tick(20);
    flag_clr = 15'h4000;
    tick(1);
    flag_clr = 15'h0;
    drv[0] = 1'b1;
    tick(8);
    check(flag_q[14], 1'b1);
    check(hall_val > 32'h8 && cnt_val[1] < hall_val, 1'b1);
    cnt_cfg[2].sync_src = awpg_pkg::SYNC_EXT;
    cnt_cfg[2].sync_mode = awpg_pkg::AWPG_SYNC_RESET;
    sync_in = 1'b1;
    tick(8);
    check(cnt_val[2] < 32'h4, 1'b1);
    check(flag_q[2], 1'b1);
    sync_clr = 1'b1;
    tick(2);
    check(flag_q | pin_oe, 32'h0);
    sync_clr = 1'b0;
    wrap_up();
  end
  // Watchdog cuts a hung run short.
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
endmodule : awpg_group_tb
